//--- core/bpio_port_if.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - Drive data only for own read or pending acknowledge
// - Decode low address byte only
// - I/O request ignored during refresh
// - Capture write data on selected write
// - Gate read data while strobe held
// - Port decode qualified by I/O request
// - I/O request with fetch is acknowledge
// - Jumper routes bus-ack out to status-0
module bpio_port_if
    import bpio_pkg::*;
#(
    parameter int SPAN = `BPIO_SPAN_RST
) (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    arst_n,
    // Backplane inputs
    input  wire logic [`BPIO_ADDR_W-1:0] addr,
    input  wire logic                    iorq_n,
    input  wire logic                    rd_n,
    input  wire logic                    wr_n,
    input  wire logic                    m1_n,
    input  wire logic                    rfsh_n,
    input  wire logic                    mreq_n,
    input  wire logic                    busak_in_n,
    input  wire logic [`BPIO_DATA_W-1:0] data_in,
    // Backplane outputs
    output var  logic [`BPIO_DATA_W-1:0] data_out,
    output var  logic                    data_oe_n,
    output var  logic                    status0_out,
    output var  logic                    status0_oe_n,
    // Card configuration straps
    input  wire logic [`BPIO_PORT_W-1:0] port_base,
    input  wire logic                    status0_jumper,
    input  wire logic [`BPIO_DATA_W-1:0] intack_vector,
    input  wire logic                    intack_pending,
    // Card function side
    input  wire logic [`BPIO_DATA_W-1:0] rd_data,
    output var  logic                    wr_valid,
    output var  bpio_wr_s                wr_info,
    output var  logic                    rd_req,
    output var  logic [`BPIO_PORT_W-1:0] rd_port,
    output var  logic                    intack_seen,
    output var  logic                    cycle_active
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    initial begin
        if (SPAN < 1 || SPAN > 256) begin
            $error("SPAN must be 1 to 256");
        end
        if (`BPIO_PORT_W > `BPIO_ADDR_W) begin
            $error("port field wider than address bus");
        end
        if (`BPIO_SYNC_STAGES != 2) begin
            $error("synchroniser depth must be two");
        end
    end

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int SW = 7 + `BPIO_ADDR_W + `BPIO_DATA_W;

    logic [SW-1:0] raw_in;
    logic [SW-1:0] syn_q;
    bpio_strb_s    strb;
    logic [`BPIO_ADDR_W-1:0] addr_s;
    bpio_data_t    din_s;

    // Every backplane pin crosses into the card clock through two flops,
    // so decode lags the pins by two edges and answers land on the third
    assign raw_in = {iorq_n, rd_n, wr_n, m1_n, rfsh_n, mreq_n, busak_in_n, addr, data_in};

    bpio_sync #(
        .W   (SW),
        .RST ({7'h7f, {(SW-7){1'b0}}})
    ) u_sync (
        .clock  (clock),
        .arst_n (arst_n),
        .d      (raw_in),
        .q      (syn_q)
    );

    assign strb   = bpio_strb_s'(syn_q[SW-1 -: 7]);
    assign addr_s = syn_q[`BPIO_ADDR_W+`BPIO_DATA_W-1 -: `BPIO_ADDR_W];
    assign din_s  = syn_q[`BPIO_DATA_W-1:0];

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic [`BPIO_PORT_W-1:0] port_lo;
    logic [8:0]              port_off;
    logic                    in_range;
    logic                    io_req;
    logic                    sel;
    logic                    inta;
    bpio_cycle_e             cyc_next;
    bpio_cycle_e             cyc_reg;

    // Upper address bits and memory request play no part
    assign port_lo  = addr_s[`BPIO_PORT_W-1:0];
    // One spare bit keeps a port below the base from wrapping into range
    assign port_off = {1'b0, port_lo} - {1'b0, port_base};
    assign in_range = (port_lo >= port_base) && (port_off < 9'(SPAN));
    assign io_req   = !strb.iorq_n && strb.rfsh_n;
    assign inta     = io_req && !strb.m1_n;
    assign sel      = io_req && strb.m1_n && in_range;

    // Classify the current bus cycle
    always_comb begin
        cyc_next = BPIO_IDLE;
        if (inta) begin
            cyc_next = BPIO_INTA;
        end else if (sel && !strb.rd_n) begin
            cyc_next = BPIO_READ;
        end else if (sel && !strb.wr_n) begin
            cyc_next = BPIO_WRITE;
        end
    end

    // Cycle kind register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cyc_reg <= BPIO_IDLE;
        end else begin
            cyc_reg <= cyc_next;
        end
    end

    // ****************************************************************
    // Write capture, one pulse per write cycle
    // ****************************************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_valid <= 1'b0;
            wr_info  <= '0;
        end else begin
            wr_valid <= (cyc_next == BPIO_WRITE) && (cyc_reg != BPIO_WRITE);
            if (cyc_next == BPIO_WRITE) begin
                wr_info <= '{port: port_lo, data: din_s};
            end
        end
    end

    // ****************************************************************
    // Read start pulse and port towards the card's functions
    // ****************************************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_req  <= 1'b0;
            rd_port <= '0;
        end else begin
            rd_req  <= (cyc_next == BPIO_READ) && (cyc_reg != BPIO_READ);
            rd_port <= port_lo;
        end
    end

    // ****************************************************************
    // Data bus drive for own reads and acknowledges
    // ****************************************************************
    // Enable follows the decoded cycle, so the bus is let go three edges
    // after the strobe rises; the master must not reuse it sooner
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            data_out  <= '0;
            data_oe_n <= 1'b1;
        end else begin
            case (cyc_next)
                BPIO_READ: begin
                    data_out  <= rd_data;
                    data_oe_n <= 1'b0;
                end
                BPIO_INTA: begin
                    data_out  <= intack_vector;
                    data_oe_n <= !intack_pending;
                end
                default: begin
                    data_out  <= '0;
                    data_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************************************
    // Status flags and status-0 jumper
    // ****************************************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            intack_seen  <= 1'b0;
            cycle_active <= 1'b0;
        end else begin
            intack_seen  <= inta && (cyc_reg != BPIO_INTA);
            cycle_active <= sel;
        end
    end

    // Bus-ack out passed to status-0 only when jumpered
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            status0_out  <= 1'b1;
            status0_oe_n <= 1'b1;
        end else begin
            status0_out  <= strb.busak_n;
            status0_oe_n <= !status0_jumper;
        end
    end
endmodule

`default_nettype wire

//--- core/bpio_params.svh
`ifndef BPIO_PARAMS_SVH
`define BPIO_PARAMS_SVH

// ********************************************************************
// Bus widths and decode defaults
// ********************************************************************
`define BPIO_DATA_W      8
`define BPIO_ADDR_W      16
`define BPIO_PORT_W      8
`define BPIO_BASE_RST    8'h00
`define BPIO_SPAN_RST    4
`define BPIO_IVEC_RST    8'hff
`define BPIO_SYNC_STAGES 2

`endif

//--- core/bpio_pkg.sv
`include "bpio_params.svh"

package bpio_pkg;

    // ****************************************************************
    // Bus cycle kinds and carriers
    // ****************************************************************
    typedef enum logic [1:0] {
        BPIO_IDLE  = 2'b00,
        BPIO_WRITE = 2'b01,
        BPIO_READ  = 2'b10,
        BPIO_INTA  = 2'b11
    } bpio_cycle_e;

    typedef logic [`BPIO_DATA_W-1:0] bpio_data_t;

    // Synchronised backplane strobes, all active low
    typedef struct packed {
        logic iorq_n;
        logic rd_n;
        logic wr_n;
        logic m1_n;
        logic rfsh_n;
        logic mreq_n;
        logic busak_n;
    } bpio_strb_s;

    // Captured port write towards the card's functions
    typedef struct packed {
        logic [`BPIO_PORT_W-1:0] port;
        bpio_data_t              data;
    } bpio_wr_s;
endpackage

//--- core/bpio_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a bundle of asynchronous bus inputs
module bpio_sync #(
    parameter int W   = 8,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         arst_n,
    // Data
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= RST;
            q        <= RST;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

`default_nettype wire

//--- sim/bpio_port_if_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// Timing checks at the card's pins; decisions land three edges after the pins move
module bpio_port_if_assertions
    import bpio_pkg::*;
#(
    parameter int SPAN = 4
) (
    // Bus side and straps
    input wire logic        clock, arst_n, iorq_n, rd_n, wr_n, m1_n, rfsh_n,
    input wire logic        busak_in_n, status0_jumper, intack_pending,
    input wire logic [15:0] addr,
    input wire logic [7:0]  data_in, port_base,
    // Card outputs
    input wire logic        data_oe_n, status0_out, status0_oe_n,
    input wire logic        wr_valid, rd_req, intack_seen, cycle_active,
    input wire bpio_wr_s    wr_info
);
    int   ofs;
    logic sel;

    // Port decode as seen on the pins
    assign ofs = int'(addr[7:0]) - int'(port_base);
    assign sel = !iorq_n && m1_n && rfsh_n && ofs >= 0 && ofs < SPAN;

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_drive_own_read: assert property (
        !data_oe_n |-> $past(sel && !rd_n, 3) ||
            $past(rfsh_n && !iorq_n && !m1_n, 3) && $past(intack_pending))
        else $error("data bus driven outside own read");
    a_write_select: assert property (wr_valid |-> $past(sel && !wr_n && rd_n, 3))
        else $error("write pulse without selected write");
    a_write_pulse: assert property (wr_valid |=> !wr_valid)
        else $error("write pulse longer than one cycle");
    a_write_data: assert property (
        wr_valid |-> wr_info == {$past(addr[7:0], 3), $past(data_in, 3)})
        else $error("write port or data wrong");
    a_read_select: assert property (rd_req |-> $past(sel && !rd_n, 3))
        else $error("read start without selected read");
    a_refresh_blocks: assert property (
        $past(!rfsh_n, 3) |-> !cycle_active && !wr_valid && !rd_req)
        else $error("refresh cycle selected the card");
    a_ack_not_port: assert property (
        intack_seen |-> $past(!iorq_n && !m1_n, 3) && !wr_valid && !rd_req)
        else $error("acknowledge mistaken for port access");
    a_select_range: assert property (cycle_active |-> $past(sel, 3))
        else $error("card active outside its range");
    a_status_route: assert property (
        $past(arst_n, 3) && $stable(status0_jumper) |-> status0_oe_n == !status0_jumper &&
            (status0_oe_n || status0_out == $past(busak_in_n, 3)))
        else $error("status pin routing wrong");
endmodule

`default_nettype wire

//--- sim/bpio_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// Bus master: one bus cycle at a time, strobes held five edges
module bpio_master_model (
    input  wire logic        clock,
    input  wire logic [7:0]  data_out,
    input  wire logic        data_oe_n,
    output var  logic [15:0] addr,
    output var  logic        iorq_n, rd_n, wr_n, m1_n, rfsh_n, mreq_n,
    output var  logic [7:0]  data_in, rdata,
    output var  logic        machine_cycle_sync
);
    logic       drv;
    logic       step_latch;
    logic [7:0] dval;

    // A released bus shows the inverse of the data byte given to the last cycle
    assign data_in = !data_oe_n ? data_out : dval ^ {8{!drv}};

    // Cycle sync built from read, write and acknowledge; the card never sees it
    assign machine_cycle_sync = !rd_n || !wr_n || !iorq_n && !m1_n;

    // Idle bus
    initial begin
        {iorq_n, rd_n, wr_n, m1_n, rfsh_n, mreq_n} = '1;
        {addr, drv, dval, rdata} = '0;
        step_latch = 1'b1;
    end

    // Kinds: 0 write, 1 read, 2 acknowledge, 3 refresh with stray write strobes
    task automatic run(input int k, input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        #2;
        addr = k == 3 ? {8'h5a, 1'b0, a[6:0]}
                      : a | {{3{step_latch}}, 13'h0000};
        {dval, drv} = {d, k == 0 || k == 3};
        iorq_n = 1'b0;
        wr_n = !(k == 0 || k == 3);
        rd_n = k != 1;
        m1_n = k != 2;
        {rfsh_n, mreq_n} = {2{k != 3}};
        repeat (5) @(posedge clock);
        rdata = data_in;
        #2;
        {iorq_n, rd_n, wr_n, m1_n, rfsh_n, mreq_n, drv} = 7'h7e;
        step_latch = step_latch && k == 3;
    endtask
endmodule

`default_nettype wire

//--- sim/bpio_port_if_tb.sv
`timescale 1ns/1ps
`default_nettype none

module bpio_port_if_tb;
    typedef struct packed {
        logic [1:0] k; logic p; logic [15:0] a; logic [7:0] d;
        logic ew, er, ea, ck; logic [7:0] ed;
    } bpio_row_s;

    logic        clock = 0, arst_n = 0, busak_in_n = 1, status0_jumper = 0;
    logic        intack_pending = 0, iorq_n, rd_n, wr_n, m1_n, rfsh_n, mreq_n;
    logic        data_oe_n, status0_out, status0_oe_n, wr_valid, rd_req, intack_seen;
    logic        cycle_active, machine_cycle_sync;
    logic [7:0]  rd_data = 0, data_out, data_in, rdata, rd_port;
    logic [15:0] addr, wr_info, got_info, n_wr, n_rd, n_ack, n_act, n_sync;
    int          failures = 0, checked = 0;
    // Kind, pending, address, data, expected write/read/ack, data check, expected byte
    bpio_row_s   rows [9] = '{
        '{0, 0, 16'hab40, 8'h3c, 1, 0, 0, 0, 8'h00}, '{0, 0, 16'h0043, 8'hc5, 1, 0, 0, 0, 8'h00},
        '{0, 0, 16'h0044, 8'h11, 0, 0, 0, 0, 8'h00}, '{0, 0, 16'h003f, 8'h22, 0, 0, 0, 0, 8'h00},
        '{1, 0, 16'hff42, 8'h96, 0, 1, 0, 1, 8'h96}, '{1, 0, 16'h0044, 8'h55, 0, 0, 0, 0, 8'h00},
        '{2, 1, 16'h0040, 8'h00, 0, 0, 1, 1, 8'hd7}, '{2, 0, 16'h0041, 8'h00, 0, 0, 1, 0, 8'h00},
        '{3, 0, 16'h0041, 8'h77, 0, 0, 0, 0, 8'h00}};

    bpio_port_if #(.SPAN(4)) i_dut (
        .clock, .arst_n, .addr, .iorq_n, .rd_n, .wr_n, .m1_n, .rfsh_n, .mreq_n,
        .busak_in_n, .data_in, .data_out, .data_oe_n, .status0_out, .status0_oe_n,
        .port_base(8'h40), .status0_jumper, .intack_vector(8'hd7), .intack_pending,
        .rd_data, .wr_valid, .wr_info, .rd_req, .rd_port, .intack_seen, .cycle_active);
    bpio_master_model i_master (.clock, .data_out, .data_oe_n, .addr, .iorq_n, .rd_n,
        .wr_n, .m1_n, .rfsh_n, .mreq_n, .data_in, .rdata, .machine_cycle_sync);

    // Clock
    initial forever #20 clock = ~clock;

    // Count card-side pulses and the master's cycle sync, and keep the last write
    always @(posedge clock) begin
        n_wr += 16'(wr_valid === 1'b1);
        n_rd += 16'(rd_req === 1'b1);
        n_ack += 16'(intack_seen === 1'b1);
        n_act += 16'(cycle_active === 1'b1);
        n_sync += 16'(machine_cycle_sync === 1'b1);
        if (wr_valid === 1'b1) got_info = wr_info;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    task automatic check(input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Reset, table of bus cycles, status pin routing, then reset during a selected read
    initial begin
        tick(2);
        check(16'({data_oe_n, status0_oe_n, status0_out}), 16'h7);
        $display("reset test done");
        tick(14);
        arst_n = 1'b1;
        tick(2);
        foreach (rows[i]) begin
            {intack_pending, rd_data} = {rows[i].p, rows[i].d};
            {n_wr, n_rd, n_ack, n_act, n_sync} = '0;
            i_master.run(rows[i].k, rows[i].a, rows[i].d);
            tick(5);
            check(n_wr, 16'(rows[i].ew));
            check(n_rd, 16'(rows[i].er));
            check(n_ack, 16'(rows[i].ea));
            check(n_act, 16'((rows[i].ew || rows[i].er) ? 5 : 0));
            check(n_sync, 16'h5);
            if (rows[i].er) check(16'(rd_port), 16'(rows[i].a[7:0]));
            if (rows[i].ew) check(got_info, {rows[i].a[7:0], rows[i].d});
            if (rows[i].ck) check(16'(rdata), 16'(rows[i].ed));
            check(16'(data_oe_n), 16'h1);
            $display("row %0d done", i);
        end
        status0_jumper = 1'b1;
        busak_in_n = 1'b0;
        tick(5);
        check(16'({status0_oe_n, status0_out}), 16'h0);
        busak_in_n = 1'b1;
        tick(5);
        check(16'({status0_oe_n, status0_out}), 16'h1);
        $display("status route test done");
        // Reset in the middle of a selected read must free the bus at once
        rd_data = 8'h5a;
        fork
            i_master.run(1, 16'h0042, 8'h5a);
            begin
                tick(4);
                check(16'(data_oe_n), 16'h0);
                arst_n = 1'b0;
                tick(1);
                check(16'({data_oe_n, status0_oe_n, status0_out}), 16'h7);
                tick(2);
                arst_n = 1'b1;
            end
        join
        n_rd = '0;
        tick(5);
        check(n_rd, 16'h0);
        check(16'({data_oe_n, status0_oe_n, status0_out}), 16'h5);
        $display("mid-run reset test done");
        final_report();
    end
endmodule

bind bpio_port_if bpio_port_if_assertions #(.SPAN(SPAN)) i_chk (
    .clock, .arst_n, .iorq_n, .rd_n, .wr_n, .m1_n, .rfsh_n, .busak_in_n, .status0_jumper,
    .intack_pending, .addr, .data_in, .port_base, .data_oe_n, .status0_out, .status0_oe_n,
    .wr_valid, .rd_req, .intack_seen, .cycle_active, .wr_info);

`default_nettype wire
